// ---- rtc_pkg.sv ----
package rtc_pkg;

	// ****************************************************************
	// Carriers
	// ****************************************************************

	// One register access from the serial bus engine.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtc_req_s;

	// Current time and date in BCD, valid on the second update.
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] date;
	} rtc_time_s;

	// Second alarm register bytes: minutes, hours, day or date.
	typedef struct packed {
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] daydate;
	} rtc_alarm2_s;

	typedef enum logic [1:0] {
		RTC_TEMP_CONVERT_REQUEST_IDLE = 2'h1,
		RTC_TEMP_CONVERT_REQUEST_RUN = 2'h2
	} rtc_temp_convert_request_e;

	// ****************************************************************
	// Register map
	// ****************************************************************

	localparam logic [7:0] ADDR_CONTROL = 8'h0E;
	localparam logic [7:0] ADDR_STATUS = 8'h0F;
	localparam logic [7:0] ADDR_AGING = 8'h10;
	localparam logic [7:0] CONTROL_RST = 8'h1C;
	localparam logic [7:0] STATUS_RST = 8'hC8;
	localparam logic [7:0] AGING_RST = 8'h00;
	localparam logic [7:0] CTL_TEMP_CONVERT_REQUEST_MASK = 8'h20;

	// Control register fields.
	localparam int B_OSC_DISABLE_ON_BATTERY = 7;
	localparam int B_BATTERY_SQWAVE_ENABLE = 6;
	localparam int B_TEMP_CONVERT_REQUEST = 5;
	localparam int B_RS_HI = 4;
	localparam int B_RS_LO = 3;
	localparam int B_IRQ_SELECT = 2;
	localparam int B_SECOND_ALARM_IRQ_ENABLE = 1;
	localparam int B_FIRST_ALARM_IRQ_ENABLE = 0;
	// Status register fields.
	localparam int B_OSF = 7;
	localparam int B_BB32 = 6;
	localparam int B_CRATE_HI = 5;
	localparam int B_CRATE_LO = 4;
	localparam int B_EN32 = 3;
	localparam int B_BSY = 2;
	localparam int B_A2F = 1;
	localparam int B_A1F = 0;
	// Alarm byte fields.
	localparam int B_MASK = 7;
	localparam int B_DYDT = 6;
	localparam logic [7:0] SEC_ZERO = 8'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************

	// Automatic conversion periods, in seconds.
	localparam logic [9:0] TEMP_CONVERT_REQUEST_PERIOD_64 = 10'h040;
	localparam logic [9:0] TEMP_CONVERT_REQUEST_PERIOD_128 = 10'h080;
	localparam logic [9:0] TEMP_CONVERT_REQUEST_PERIOD_256 = 10'h100;
	localparam logic [9:0] TEMP_CONVERT_REQUEST_PERIOD_512 = 10'h200;
	// Divider taps on the 65.536 kHz oscillator tick.
	localparam int DIV_W = 16;
	localparam int TAP_32K = 0;
	localparam int TAP_8K = 2;
	localparam int TAP_4K = 3;
	localparam int TAP_1K = 5;
	localparam int TAP_1HZ = 15;

endpackage

// ---- rtc_ctrl_status.sv ----
`timescale 1ns/1ps
// Functional notes
// - All masks set: alarm at 00 seconds
// - Minutes mask only clear: match minutes
// - No masks: day or date, hours, minutes
// - Oscillator stops only on battery when disabled
// - Battery without enable: shared pin floats
// - Convert write starts conversion unless busy
// - Convert bit clears with busy on completion
// - User conversion leaves automatic schedule alone
// - Rate bits pick square-wave frequency
// - Interrupt select picks square wave or alarm
// - Alarm match always sets its flag
// - Second flag interrupts only when enabled
// - First flag interrupts only when enabled
// - Oscillator stop flag sticky until written zero
// - On battery fixed clock needs battery enable
// - Conversion rate bits pick sampling period
// - New rate applies within one period
// - Fixed clock output enable or low
// - Busy follows the sensor conversion request
// - Flag set on match, pin if enabled
// - Flags clear on zero, one keeps
// - Alarms checked on the second update
// - Top bit of alarm byte masks field
// - Bit six selects day or date
module rtc_ctrl_status (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic osc_clk,
	input rtc_pkg::rtc_req_s bus_req,
	output logic [7:0] bus_rdata,
	input wire logic on_battery,
	input wire logic osc_running,
	input wire logic sec_tick,
	input rtc_pkg::rtc_time_s now,
	input rtc_pkg::rtc_alarm2_s alarm2_cfg,
	input wire logic first_alarm_match,
	input wire logic temp_convert_request_done,
	output logic temp_convert_request_start,
	output logic osc_enable,
	output logic [7:0] aging_trim,
	output logic pin_out,
	output logic pin_oe_b,
	output logic fixed_clk_out
);

	// ****************************************************************
	// Reset and input synchronisers
	// ****************************************************************

	logic [1:0] rst_ff;
	logic rst_n;
	logic [1:0] bat_ff;
	logic [1:0] run_ff;
	logic [3:0] tap_m;
	logic [3:0] tap_s;
	logic [3:0] sq_taps;
	logic bat_s;
	logic run_s;

	// Reset is released through two flops so all clk-domain logic leaves reset together.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_ff <= 2'h0;
		end else begin
			rst_ff <= {rst_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_ff[1];

	// Supply and oscillator status pins, and the divider taps, are asynchronous.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bat_ff <= 2'h0;
			run_ff <= 2'h0;
			tap_m <= 4'h0;
			tap_s <= 4'h0;
		end else begin
			bat_ff <= {bat_ff[0], on_battery};
			run_ff <= {run_ff[0], osc_running};
			tap_m <= sq_taps;
			tap_s <= tap_m;
		end
	end
	assign bat_s = bat_ff[1];
	assign run_s = run_ff[1];

	// ****************************************************************
	// Register file
	// ****************************************************************

	logic [7:0] ctl;
	logic osc_stop_flag;
	logic bb32;
	logic [1:0] crate;
	logic en32;
	logic a1f;
	logic a2f;
	logic busy;
	logic wr_ctl;
	logic wr_sts;
	logic user_go;
	logic temp_convert_request_go;
	logic a2_hit;
	logic osc_stopped;
	rtc_pkg::rtc_temp_convert_request_e temp_convert_request_state;

	assign wr_ctl = bus_req.wr && (bus_req.addr == rtc_pkg::ADDR_CONTROL);
	assign wr_sts = bus_req.wr && (bus_req.addr == rtc_pkg::ADDR_STATUS);
	assign busy = (temp_convert_request_state == rtc_pkg::RTC_TEMP_CONVERT_REQUEST_RUN);
	assign osc_stopped = !run_s || (bat_s && ctl[rtc_pkg::B_OSC_DISABLE_ON_BATTERY]);

	// Control byte; the convert bit is owned by the conversion logic.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= rtc_pkg::CONTROL_RST;
		end else begin
			if (wr_ctl) begin
				ctl <= (bus_req.wdata & ~rtc_pkg::CTL_TEMP_CONVERT_REQUEST_MASK) | (ctl & rtc_pkg::CTL_TEMP_CONVERT_REQUEST_MASK);
			end
			if (user_go) begin
				ctl[rtc_pkg::B_TEMP_CONVERT_REQUEST] <= 1'b1;
			end else if (busy && temp_convert_request_done) begin
				ctl[rtc_pkg::B_TEMP_CONVERT_REQUEST] <= 1'b0;
			end
		end
	end

	// Writable status fields and the trim byte.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bb32 <= rtc_pkg::STATUS_RST[rtc_pkg::B_BB32];
			crate <= rtc_pkg::STATUS_RST[rtc_pkg::B_CRATE_HI:rtc_pkg::B_CRATE_LO];
			en32 <= rtc_pkg::STATUS_RST[rtc_pkg::B_EN32];
			aging_trim <= rtc_pkg::AGING_RST;
		end else begin
			if (wr_sts) begin
				bb32 <= bus_req.wdata[rtc_pkg::B_BB32];
				crate <= bus_req.wdata[rtc_pkg::B_CRATE_HI:rtc_pkg::B_CRATE_LO];
				en32 <= bus_req.wdata[rtc_pkg::B_EN32];
			end
			if (bus_req.wr && (bus_req.addr == rtc_pkg::ADDR_AGING)) begin
				aging_trim <= bus_req.wdata;
			end
		end
	end

	// Sticky flags: a hardware set in the same cycle as a clear wins.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_stop_flag <= rtc_pkg::STATUS_RST[rtc_pkg::B_OSF];
			a1f <= rtc_pkg::STATUS_RST[rtc_pkg::B_A1F];
			a2f <= rtc_pkg::STATUS_RST[rtc_pkg::B_A2F];
		end else begin
			if (osc_stopped) begin
				osc_stop_flag <= 1'b1;
			end else if (wr_sts && !bus_req.wdata[rtc_pkg::B_OSF]) begin
				osc_stop_flag <= 1'b0;
			end
			if (first_alarm_match) begin
				a1f <= 1'b1;
			end else if (wr_sts && !bus_req.wdata[rtc_pkg::B_A1F]) begin
				a1f <= 1'b0;
			end
			if (a2_hit) begin
				a2f <= 1'b1;
			end else if (wr_sts && !bus_req.wdata[rtc_pkg::B_A2F]) begin
				a2f <= 1'b0;
			end
		end
	end

	// Read data is registered; unmapped addresses read as zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				rtc_pkg::ADDR_CONTROL: bus_rdata <= ctl;
				rtc_pkg::ADDR_STATUS: bus_rdata <= {osc_stop_flag, bb32, crate, en32, busy, a2f, a1f};
				rtc_pkg::ADDR_AGING: bus_rdata <= aging_trim;
				default: bus_rdata <= 8'h00;
			endcase
		end
	end

	// The oscillator may only be stopped while the battery carries the part.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_enable <= 1'b1;
		end else begin
			osc_enable <= !(bat_s && ctl[rtc_pkg::B_OSC_DISABLE_ON_BATTERY]);
		end
	end

	// ****************************************************************
	// Second alarm decode
	// ****************************************************************

	function automatic logic fld_ok(input logic mask, input logic [6:0] a, input logic [6:0] b);
		return mask || (a == b);
	endfunction

	logic [5:0] a2_dd_now;
	logic a2_match;

	// Day of week or date of month, chosen by the alarm's select bit.
	assign a2_dd_now = alarm2_cfg.daydate[rtc_pkg::B_DYDT] ? now.day[5:0] : now.date[5:0];
	// A masked field always matches; masks 111 leave only the seconds check.
	assign a2_match = (now.sec == rtc_pkg::SEC_ZERO)
		&& fld_ok(alarm2_cfg.min[rtc_pkg::B_MASK], alarm2_cfg.min[6:0], now.min[6:0])
		&& fld_ok(alarm2_cfg.hour[rtc_pkg::B_MASK], alarm2_cfg.hour[6:0], now.hour[6:0])
		&& fld_ok(alarm2_cfg.daydate[rtc_pkg::B_MASK], {1'b0, alarm2_cfg.daydate[5:0]},
			{1'b0, a2_dd_now});
	assign a2_hit = sec_tick && a2_match;

	// ****************************************************************
	// Temperature conversion
	// ****************************************************************

	function automatic logic [9:0] temp_convert_request_period(input logic [1:0] rate);
		case (rate)
			2'h0: return rtc_pkg::TEMP_CONVERT_REQUEST_PERIOD_64;
			2'h1: return rtc_pkg::TEMP_CONVERT_REQUEST_PERIOD_128;
			2'h2: return rtc_pkg::TEMP_CONVERT_REQUEST_PERIOD_256;
			default: return rtc_pkg::TEMP_CONVERT_REQUEST_PERIOD_512;
		endcase
	endfunction

	logic [9:0] sec_cnt;
	logic auto_due;
	logic auto_pend;

	assign auto_due = sec_tick && (sec_cnt >= temp_convert_request_period(crate) - 10'h001);
	// A request while busy is dropped; the host is expected to check busy first.
	assign user_go = wr_ctl && bus_req.wdata[rtc_pkg::B_TEMP_CONVERT_REQUEST] && !busy;
	assign temp_convert_request_go = !busy && (user_go || auto_pend || auto_due);

	// Seconds counter of the automatic schedule; user requests never touch it.
	// After a rate change the count just runs on, so the new period takes hold
	// within one period of the new rate.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_cnt <= 10'h000;
		end else if (auto_due) begin
			sec_cnt <= 10'h000;
		end else if (sec_tick) begin
			sec_cnt <= sec_cnt + 10'h001;
		end
	end

	// A due automatic conversion waits out a running user conversion.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_pend <= 1'b0;
		end else if (temp_convert_request_go) begin
			auto_pend <= 1'b0;
		end else if (auto_due) begin
			auto_pend <= 1'b1;
		end
	end

	// Conversion state: busy from the sensor request until its completion.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_convert_request_state <= rtc_pkg::RTC_TEMP_CONVERT_REQUEST_IDLE;
			temp_convert_request_start <= 1'b0;
		end else begin
			temp_convert_request_start <= temp_convert_request_go;
			case (temp_convert_request_state)
				rtc_pkg::RTC_TEMP_CONVERT_REQUEST_IDLE: begin
					if (temp_convert_request_go) begin
						temp_convert_request_state <= rtc_pkg::RTC_TEMP_CONVERT_REQUEST_RUN;
					end
				end
				rtc_pkg::RTC_TEMP_CONVERT_REQUEST_RUN: begin
					if (temp_convert_request_done) begin
						temp_convert_request_state <= rtc_pkg::RTC_TEMP_CONVERT_REQUEST_IDLE;
					end
				end
				default: temp_convert_request_state <= rtc_pkg::RTC_TEMP_CONVERT_REQUEST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Shared interrupt or square-wave pin
	// ****************************************************************

	logic irq_act;
	logic pin_en;
	logic fixed_en;

	assign irq_act = ctl[rtc_pkg::B_IRQ_SELECT]
		&& ((ctl[rtc_pkg::B_FIRST_ALARM_IRQ_ENABLE] && a1f)
		|| (ctl[rtc_pkg::B_SECOND_ALARM_IRQ_ENABLE] && a2f));
	assign pin_en = !bat_s || ctl[rtc_pkg::B_BATTERY_SQWAVE_ENABLE];

	// Interrupt mode is open drain: released unless an enabled flag is set.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_oe_b <= 1'b1;
			pin_out <= 1'b1;
		end else if (!pin_en) begin
			pin_oe_b <= 1'b1;
			pin_out <= 1'b1;
		end else if (!ctl[rtc_pkg::B_IRQ_SELECT]) begin
			pin_oe_b <= 1'b0;
			pin_out <= tap_s[ctl[rtc_pkg::B_RS_HI:rtc_pkg::B_RS_LO]];
		end else begin
			pin_oe_b <= !irq_act;
			pin_out <= 1'b0;
		end
	end

	// Enable for the fixed clock, handed to the oscillator domain as a level.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fixed_en <= 1'b0;
		end else begin
			fixed_en <= en32 && (!bat_s || bb32);
		end
	end

	// ****************************************************************
	// Oscillator domain
	// ****************************************************************

	logic [1:0] orst_ff;
	logic orst_n;
	logic [1:0] fen_ff;
	logic [rtc_pkg::DIV_W-1:0] div_cnt;

	always_ff @(posedge osc_clk or negedge rst_b) begin
		if (!rst_b) begin
			orst_ff <= 2'h0;
		end else begin
			orst_ff <= {orst_ff[0], 1'b1};
		end
	end
	assign orst_n = orst_ff[1];

	// Each tap is its own level, so the clk side can sync them bit by bit
	// without a multi-bit word crossing.
	always_ff @(posedge osc_clk or negedge orst_n) begin
		if (!orst_n) begin
			fen_ff <= 2'h0;
			div_cnt <= '0;
			sq_taps <= 4'h0;
			fixed_clk_out <= 1'b0;
		end else begin
			fen_ff <= {fen_ff[0], fixed_en};
			div_cnt <= div_cnt + 16'h0001;
			sq_taps <= {div_cnt[rtc_pkg::TAP_8K], div_cnt[rtc_pkg::TAP_4K],
				div_cnt[rtc_pkg::TAP_1K], div_cnt[rtc_pkg::TAP_1HZ]};
			fixed_clk_out <= fen_ff[1] && div_cnt[rtc_pkg::TAP_32K];
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_flag_first_set: assert property (first_alarm_match |=> a1f)
		else $error("first alarm flag not set on match");
	a_flag_second_set: assert property (a2_hit |=> a2f)
		else $error("second alarm flag not set on match");
	a_flag_keep_one: assert property (
		wr_sts && bus_req.wdata[rtc_pkg::B_A2F] && a2f |=> a2f)
		else $error("writing one changed the second alarm flag");
	a_min_alarm: assert property (sec_tick && now.sec == rtc_pkg::SEC_ZERO
		&& alarm2_cfg.min[rtc_pkg::B_MASK] && alarm2_cfg.hour[rtc_pkg::B_MASK]
		&& alarm2_cfg.daydate[rtc_pkg::B_MASK] |=> a2f)
		else $error("fully masked alarm missed the minute");
	a_irq_asserts: assert property (pin_en && irq_act |=> (pin_oe_b == 1'b0))
		else $error("enabled alarm flag did not pull the pin");
	a_irq_masked: assert property (pin_en && ctl[rtc_pkg::B_IRQ_SELECT] && !irq_act
		|=> pin_oe_b)
		else $error("pin pulled without an enabled flag");
	a_pin_float: assert property (bat_s && !ctl[rtc_pkg::B_BATTERY_SQWAVE_ENABLE] |=> pin_oe_b)
		else $error("pin driven on battery without enable");
	a_osc_on_main: assert property (!bat_s |=> osc_enable)
		else $error("oscillator stopped on main supply");
	a_osf_sticky: assert property (osc_stop_flag && !(wr_sts && !bus_req.wdata[rtc_pkg::B_OSF])
		|=> osc_stop_flag)
		else $error("oscillator stop flag dropped without a write");
	a_busy_start: assert property (temp_convert_request_start |-> busy && $past(!busy))
		else $error("busy not raised with the sensor request");
	a_temp_convert_request_clear: assert property (busy && temp_convert_request_done && ctl[rtc_pkg::B_TEMP_CONVERT_REQUEST]
		|=> !busy && !ctl[rtc_pkg::B_TEMP_CONVERT_REQUEST])
		else $error("convert and busy did not clear together");
	a_temp_convert_request_refused: assert property (wr_ctl && busy && !ctl[rtc_pkg::B_TEMP_CONVERT_REQUEST]
		&& !temp_convert_request_done |=> !ctl[rtc_pkg::B_TEMP_CONVERT_REQUEST])
		else $error("convert accepted while busy");
	a_fixed_off: assert property (bat_s && !bb32 |=> !fixed_en)
		else $error("fixed clock enabled on battery");

	c_user_temp_convert_request: cover property (user_go ##[1:20] (busy && temp_convert_request_done));
	c_second_alarm: cover property (a2_hit ##2 !pin_oe_b);
	c_auto_temp_convert_request: cover property (auto_due && temp_convert_request_go);
	c_auto_waits: cover property (auto_due && busy ##[1:50] temp_convert_request_start);

endmodule

// ---- rtc_host_model.sv ----
`timescale 1ns/1ps
// ********
// Host processor stand-in on the register strobe bus
// ********
module rtc_host_model (
	input wire logic clk,
	output rtc_pkg::rtc_req_s req,
	input wire logic [7:0] rdata
);
	initial req = '0;

	// One write: request held from just after an edge to the next edge.
	// Data is inverted once the strobe drops, so a stale byte never looks valid.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 req = '{1'b1, 1'b0, a, d};
		@(posedge clk);
		#1 req = '{1'b0, 1'b0, a, ~d};
	endtask

	// One read: read data is taken one cycle after the request edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1 req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		#1 d = rdata;
		req.rd = 1'b0;
	endtask

	// A conversion is only requested once the busy bit reads clear.
	task automatic convert(input logic [7:0] ctl, output logic ok);
		logic [7:0] s;
		rd(rtc_pkg::ADDR_STATUS, s);
		ok = !s[rtc_pkg::B_BSY];
		if (ok) begin
			wr(rtc_pkg::ADDR_CONTROL, ctl | rtc_pkg::CTL_TEMP_CONVERT_REQUEST_MASK);
		end
	endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e, m) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("BAD %0t %s", $time, m); \
	end \
end
module tb;
	// ********
	// Wiring
	// ********
	logic clk = 1'b0;
	logic osc_clk = 1'b0;
	logic rst_b = 1'b0;
	logic on_battery = 1'b0;
	logic osc_running = 1'b1;
	logic sec_tick = 1'b0;
	logic first_alarm_match = 1'b0;
	logic temp_convert_request_done = 1'b0;
	rtc_pkg::rtc_time_s now = '0;
	rtc_pkg::rtc_alarm2_s alarm2_cfg = '0;
	rtc_pkg::rtc_req_s bus_req;
	logic [7:0] bus_rdata, aging_trim, d, x;
	logic temp_convert_request_start, osc_enable, pin_out, pin_oe_b, fixed_clk_out, ok;
	int error_cnt = 0;
	int comparisons = 0;
	int n_temp_convert_request = 0;
	int cyc = 0;
	int sens_dly = 2;
	int n, c0;
	logic [7:0] ra[4] = '{rtc_pkg::ADDR_CONTROL, rtc_pkg::ADDR_STATUS, rtc_pkg::ADDR_AGING, 8'h13};
	logic [7:0] re[4] = '{rtc_pkg::CONTROL_RST, rtc_pkg::STATUS_RST, rtc_pkg::AGING_RST, 8'h00};
	logic [2:0] masks[4] = '{3'b111, 3'b110, 3'b100, 3'b000};
	int taps[4] = '{rtc_pkg::TAP_1HZ, rtc_pkg::TAP_1K, rtc_pkg::TAP_4K, rtc_pkg::TAP_8K};

	// The link clock is offset so its edges never line up with clk.
	initial forever #2.5 clk = ~clk;
	initial begin
		#3.7;
		forever #7.5 osc_clk = ~osc_clk;
	end

	rtc_ctrl_status uut (.clk(clk), .rst_b(rst_b), .osc_clk(osc_clk), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .on_battery(on_battery), .osc_running(osc_running),
		.sec_tick(sec_tick), .now(now), .alarm2_cfg(alarm2_cfg),
		.first_alarm_match(first_alarm_match), .temp_convert_request_done(temp_convert_request_done), .temp_convert_request_start(temp_convert_request_start),
		.osc_enable(osc_enable), .aging_trim(aging_trim), .pin_out(pin_out),
		.pin_oe_b(pin_oe_b), .fixed_clk_out(fixed_clk_out));
	rtc_host_model host (.clk(clk), .req(bus_req), .rdata(bus_rdata));

	// Sensor stand-in answers each request after a chosen delay.
	initial forever begin
		@(posedge clk iff temp_convert_request_start === 1'b1);
		repeat (sens_dly) @(posedge clk);
		#1 temp_convert_request_done = 1'b1;
		@(posedge clk);
		#1 temp_convert_request_done = 1'b0;
	end

	// Requests are counted; a hung run is cut short well past the expected length.
	always @(posedge clk) begin
		cyc++;
		if (temp_convert_request_start === 1'b1) n_temp_convert_request++;
		if (cyc == 60000) begin
			error_cnt++;
			summarize();
		end
	end

	// ********
	// Helpers
	// ********
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic tick(input rtc_pkg::rtc_time_s t);
		@(posedge clk);
		#1 sec_tick = 1'b1;
		now = t;
		@(posedge clk);
		#1 sec_tick = 1'b0;
	endtask

	// Counts level changes of the fixed clock (sel 1) or shared pin (sel 0).
	task automatic toggles(input bit sel, output int k);
		logic p, s;
		k = 0;
		p = sel ? fixed_clk_out : pin_out;
		repeat (480) begin
			@(posedge clk);
			#1 s = sel ? fixed_clk_out : pin_out;
			if (s !== p) k++;
			p = s;
		end
	endtask

	// Expected changes in 2400 ns for a divider tap of the 15 ns link tick.
	function automatic int tog_exp(input int tap);
		return 2400 / (15 << tap);
	endfunction

	function automatic logic a2_exp(input rtc_pkg::rtc_alarm2_s a, input rtc_pkg::rtc_time_s t);
		logic [5:0] dd;
		dd = a.daydate[6] ? t.day[5:0] : t.date[5:0];
		return (t.sec == 8'h00) && (a.min[7] || a.min[6:0] == t.min[6:0])
			&& (a.hour[7] || a.hour[6:0] == t.hour[6:0]) && (a.daydate[7] || a.daydate[5:0] == dd);
	endfunction

	// ********
	// Main sequence
	// ********
	initial begin
		rtc_pkg::rtc_alarm2_s a;
		rtc_pkg::rtc_time_s t;
		void'($urandom(22261));
		repeat (12) @(posedge clk);
		#1 rst_b = 1'b1;
		settle(4);
		foreach (ra[i]) begin
			host.rd(ra[i], d);
			`CHK(d, re[i], "reset value")
		end
		x = 8'($urandom);
		host.wr(rtc_pkg::ADDR_AGING, x);
		host.rd(rtc_pkg::ADDR_AGING, d);
		`CHK({d, aging_trim}, {x, x}, "aging trim")
		$display("test registers done");
		host.wr(rtc_pkg::ADDR_STATUS, 8'h48);
		host.wr(rtc_pkg::ADDR_STATUS, 8'hC8);
		host.rd(rtc_pkg::ADDR_STATUS, d);
		`CHK(d[7], 1'b0, "osc flag write one")
		osc_running = 1'b0;
		settle(8);
		osc_running = 1'b1;
		settle(8);
		host.rd(rtc_pkg::ADDR_STATUS, d);
		`CHK(d[7], 1'b1, "osc flag on stop")
		$display("test osc flag done");
		sens_dly = 40;
		c0 = n_temp_convert_request;
		host.convert(rtc_pkg::CONTROL_RST, ok);
		`CHK(ok, 1'b1, "busy clear before convert")
		host.rd(rtc_pkg::ADDR_CONTROL, d);
		`CHK(d[rtc_pkg::B_TEMP_CONVERT_REQUEST], 1'b1, "convert bit held")
		host.rd(rtc_pkg::ADDR_STATUS, d);
		`CHK(d[rtc_pkg::B_BSY], 1'b1, "busy set")
		host.wr(rtc_pkg::ADDR_CONTROL, rtc_pkg::CONTROL_RST | rtc_pkg::CTL_TEMP_CONVERT_REQUEST_MASK);
		@(posedge clk iff temp_convert_request_done === 1'b1);
		settle(2);
		host.rd(rtc_pkg::ADDR_CONTROL, d);
		`CHK(d, rtc_pkg::CONTROL_RST, "convert bit cleared")
		host.rd(rtc_pkg::ADDR_STATUS, d);
		`CHK(d[rtc_pkg::B_BSY], 1'b0, "busy cleared")
		`CHK(n_temp_convert_request - c0, 1, "one conversion")
		sens_dly = 2;
		$display("test conversion done");
		host.wr(rtc_pkg::ADDR_CONTROL, 8'h06);
		for (int i = 0; i < 48; i++) begin
			a = 24'($urandom);
			{a.daydate[7], a.hour[7], a.min[7]} = masks[i % 4];
			t = {8'($urandom), 32'($urandom)};
			if ($urandom % 2) begin
				t.min = a.min;
				t.hour = a.hour;
				t.day = a.daydate;
				t.date = a.daydate;
			end
			if ($urandom % 4 == 0) t.hour[0] = ~t.hour[0];
			if ($urandom % 2) t.sec = 8'h00;
			alarm2_cfg = a;
			tick(t);
			host.rd(rtc_pkg::ADDR_STATUS, d);
			`CHK(d[rtc_pkg::B_A2F], a2_exp(a, t), "alarm2 flag")
			`CHK({pin_oe_b, pin_out & ~pin_oe_b}, {~a2_exp(a, t), 1'b0}, "alarm2 pin")
			host.wr(rtc_pkg::ADDR_STATUS, 8'h48);
			host.rd(rtc_pkg::ADDR_STATUS, d);
			`CHK({d[1:0], pin_oe_b}, 3'b001, "flag clear")
		end
		$display("test second alarm done");
		host.wr(rtc_pkg::ADDR_CONTROL, 8'h05);
		first_alarm_match = 1'b1;
		@(posedge clk);
		#1 first_alarm_match = 1'b0;
		host.wr(rtc_pkg::ADDR_STATUS, 8'h4B);
		host.rd(rtc_pkg::ADDR_STATUS, d);
		`CHK(d[1:0], 2'b01, "first flag kept")
		`CHK({pin_oe_b, pin_out}, 2'b00, "first alarm pin")
		host.wr(rtc_pkg::ADDR_CONTROL, 8'h04);
		settle(2);
		`CHK(pin_oe_b, 1'b1, "first alarm masked")
		host.wr(rtc_pkg::ADDR_CONTROL, 8'h01);
		settle(2);
		`CHK(pin_oe_b, 1'b0, "square wave drive")
		on_battery = 1'b1;
		settle(8);
		`CHK(pin_oe_b, 1'b1, "battery float")
		host.wr(rtc_pkg::ADDR_CONTROL, 8'hC1);
		settle(8);
		`CHK({pin_oe_b, osc_enable}, 2'b00, "battery drive, osc off")
		host.wr(rtc_pkg::ADDR_STATUS, 8'h08);
		settle(16);
		toggles(1'b1, n);
		`CHK({n == 0, fixed_clk_out}, 2'b10, "battery fixed clock low")
		host.rd(rtc_pkg::ADDR_STATUS, d);
		`CHK(d[7], 1'b1, "osc flag on battery stop")
		on_battery = 1'b0;
		settle(16);
		`CHK(osc_enable, 1'b1, "osc on main supply")
		toggles(1'b1, n);
		`CHK(n >= 159 && n <= 161, 1'b1, "fixed clock runs")
		host.wr(rtc_pkg::ADDR_STATUS, 8'h40);
		settle(16);
		toggles(1'b1, n);
		`CHK({n == 0, fixed_clk_out}, 2'b10, "fixed clock off")
		$display("test pins done");
		for (int r = 0; r < 4; r++) begin
			host.wr(rtc_pkg::ADDR_CONTROL, 8'(r << 3));
			settle(8);
			toggles(1'b0, n);
			`CHK(n >= tog_exp(taps[r]) - 1 && n <= tog_exp(taps[r]) + 1, 1'b1, "square rate")
		end
		$display("test square rate done");
		t.sec = 8'h01;
		for (int r = 0; r < 4; r++) begin
			host.wr(rtc_pkg::ADDR_STATUS, 8'h48 | 8'(r << 4));
			c0 = n_temp_convert_request;
			while (n_temp_convert_request == c0) tick(t);
			c0 = n_temp_convert_request;
			n = 0;
			while (n_temp_convert_request - c0 < 1 + int'(r == 0)) begin
				if (r == 0 && n == 20) host.convert(rtc_pkg::CONTROL_RST, ok);
				tick(t);
				n++;
			end
			`CHK(n, 64 << r, "auto period")
		end
		$display("test conversion rate done");
		summarize();
	end
endmodule
